// [shared/idb_defs.svh]
`ifndef IDB_DEFS_SVH
`define IDB_DEFS_SVH

// AXI4-Lite register map, byte addresses.
`define IDB_REG_CTRL        4'h0
`define IDB_REG_STATUS      4'h4
`define IDB_REG_INDEX       4'h8
`define IDB_REG_DATA        4'hC

// Identity block geometry.
`define IDB_BLOCK_BYTES     5'h10
`define IDB_SHORT_BYTES     5'h08
`define IDB_IDX_W           4

// Byte positions within the identity block.
`define IDB_POS_CAPS        4'h0
`define IDB_POS_VERSION     4'h1
`define IDB_POS_VID_LO      4'h2
`define IDB_POS_VID_HI      4'h3
`define IDB_POS_DID_LO      4'h4
`define IDB_POS_DID_HI      4'h5
`define IDB_POS_IFACE       4'h6
`define IDB_POS_FUNC        4'h7
`define IDB_POS_EXT         4'h8
`define IDB_POS_RSV0        4'h9
`define IDB_POS_RSV1        4'hA
`define IDB_POS_RSV2        4'hB
`define IDB_POS_VSID        4'hC
`define IDB_POS_ADDR        4'hD

// Interface-support byte bits.
`define IDB_IF_VENDOR_BIT   0
`define IDB_IF_FDESC_BIT    1
`define IDB_IF_PCIE_BIT     2
`define IDB_IF_SATA_BIT     3
`define IDB_IF_ASF_BIT      4
`define IDB_IF_IPMI_BIT     5
`define IDB_IF_RSV6_BIT     6
`define IDB_IF_RSV7_BIT     7

// Fixed field values.
`define IDB_ZERO_BYTE       8'h00
`define IDB_SST_VERSION     3'h1
`define IDB_MINOR_REV       4'h0
`define IDB_ADDR_BASE       8'h48
`define IDB_ADDR_MAX        8'h50

// Control register bits.
`define IDB_CTRL_PRERELEASE 0
`define IDB_CTRL_LEN16      1
`define IDB_CTRL_START      2

// Strap codes.
`define IDB_STRAP_GND       2'h0
`define IDB_STRAP_FLOAT     2'h1
`define IDB_STRAP_VDD       2'h2

`endif

// [shared/idb_pkg.sv]
package idb_pkg;
	typedef logic [1:0] idb_strap_t;
	typedef enum logic [1:0] {
		IDB_IDLE,
		IDB_SEND,
		IDB_DONE
	} idb_state_t;
endpackage : idb_pkg

// [shared/idb_strap_if.sv]
interface idb_strap_if;
	logic [1:0] code_low;
	logic [1:0] code_high;
	logic       valid;
	modport res (output code_low, output code_high, output valid);
	modport use_side (input code_low, input code_high, input valid);
endinterface : idb_strap_if

// [verilog/idb_strap_sampler.sv]
`include "idb_defs.svh"

module idb_strap_sampler (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  address_strap_low_hi,
	input  wire logic  address_strap_low_lo,
	input  wire logic  address_strap_high_hi,
	input  wire logic  address_strap_high_lo,
	idb_strap_if.res   strap
);
	import idb_pkg::*;

	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [1:0] settle;

	// Two-stage synchroniser on the pin comparators.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {address_strap_high_hi, address_strap_high_lo, address_strap_low_hi, address_strap_low_lo};
			sync2 <= sync1;
		end
	end

	function automatic idb_strap_t idb_decode(input logic hi, input logic lo);
		if (hi && lo)
			return `IDB_STRAP_VDD;
		else if (!hi && !lo)
			return `IDB_STRAP_GND;
		else
			return `IDB_STRAP_FLOAT; // R09
	endfunction : idb_decode

	// Straps are caught once the synchroniser holds pin levels, then held until reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle          <= 2'h0;
			strap.valid     <= 1'b0;
			strap.code_low  <= `IDB_STRAP_GND;
			strap.code_high <= `IDB_STRAP_GND;
		end else begin
			settle <= {settle[0], 1'b1};
			if (settle[1] && !strap.valid) begin // R13
				strap.code_low  <= idb_decode(sync2[1], sync2[0]);
				strap.code_high <= idb_decode(sync2[3], sync2[2]);
				strap.valid     <= 1'b1;
			end
		end
	end
endmodule : idb_strap_sampler

// [verilog/idb_identity_block.sv]
`include "idb_defs.svh"

// Contract
// R01 - Interface-support byte reports 0x02.
// R02 - Interface-support bits 7 and 6 read zero.
// R03 - Protocol bits set only when supported.
// R04 - Function-interface byte returns zero.
// R05 - Interface-extension byte returns zero.
// R06 - Three reserved bytes return zero.
// R07 - Vendor-specific distinguishing byte returns zero.
// R08 - Address is 0x48 plus low plus three-high.
// R09 - Floating strap is a distinct third level.
// R10 - Return exactly 8 or 16 requested bytes.
// R11 - Two-byte fields go LS byte first.
// R12 - Version byte: pre-release, 001, 0000.
// R13 - Straps sampled after reset, address held.
module idb_identity_block #(
	parameter logic [15:0] VENDOR_ID = 16'h0A5A,
	parameter logic [15:0] DEVICE_ID = 16'h0123,
	parameter logic [7:0]  CAPS      = 8'h00
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        address_strap_low_hi,
	input  wire logic        address_strap_low_lo,
	input  wire logic        address_strap_high_hi,
	input  wire logic        address_strap_high_lo,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [3:0]  dib_index,
	output logic [7:0]       dib_byte,
	input  wire logic        dib_req,
	input  wire logic        dib_len16,
	output logic             dib_valid,
	output logic             dib_last,
	output logic [7:0]       client_address,
	output logic             client_address_valid
);
	import idb_pkg::*;

	idb_strap_if strap ();

	idb_strap_sampler u_straps (
		.aclk                  (aclk),
		.aresetn               (aresetn),
		.address_strap_low_hi  (address_strap_low_hi),
		.address_strap_low_lo  (address_strap_low_lo),
		.address_strap_high_hi (address_strap_high_hi),
		.address_strap_high_lo (address_strap_high_lo),
		.strap                 (strap)
	);

	logic             prerelease;
	logic             sw_len16;
	logic [3:0]       sw_index;
	logic [7:0]       iface_byte;
	logic [7:0]       version_byte;
	logic [7:0]       next_client_address;
	logic [7:0]       look_byte;
	logic [3:0]       send_idx;
	logic [4:0]       send_len;
	logic             sw_start;
	logic             have_aw;
	logic             have_w;
	logic [3:0]       aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	idb_state_t       state;

	always_comb begin
		iface_byte = `IDB_ZERO_BYTE;
		iface_byte[`IDB_IF_FDESC_BIT]  = 1'b1; // R01
		iface_byte[`IDB_IF_VENDOR_BIT] = 1'b0; // R03
		iface_byte[`IDB_IF_PCIE_BIT]   = 1'b0; // R03
		iface_byte[`IDB_IF_SATA_BIT]   = 1'b0; // R03
		iface_byte[`IDB_IF_ASF_BIT]    = 1'b0; // R03
		iface_byte[`IDB_IF_IPMI_BIT]   = 1'b0; // R03
		iface_byte[`IDB_IF_RSV6_BIT]   = 1'b0; // R02
		iface_byte[`IDB_IF_RSV7_BIT]   = 1'b0; // R02
	end

	assign version_byte = {prerelease, `IDB_SST_VERSION, `IDB_MINOR_REV}; // R12
	assign next_client_address = `IDB_ADDR_BASE + {6'h00, strap.code_low}
		+ {5'h00, strap.code_high, 1'b0} + {6'h00, strap.code_high}; // R08

	function automatic logic [7:0] idb_lookup(input logic [3:0] idx, input logic [7:0] ifc,
		input logic [7:0] ver, input logic [7:0] adr);
		case (idx)
			`IDB_POS_CAPS:    return CAPS;
			`IDB_POS_VERSION: return ver;
			`IDB_POS_VID_LO:  return VENDOR_ID[7:0]; // R11
			`IDB_POS_VID_HI:  return VENDOR_ID[15:8];
			`IDB_POS_DID_LO:  return DEVICE_ID[7:0]; // R11
			`IDB_POS_DID_HI:  return DEVICE_ID[15:8];
			`IDB_POS_IFACE:   return ifc;
			`IDB_POS_FUNC:    return `IDB_ZERO_BYTE; // R04
			`IDB_POS_EXT:     return `IDB_ZERO_BYTE; // R05
			`IDB_POS_RSV0,
			`IDB_POS_RSV1,
			`IDB_POS_RSV2:    return `IDB_ZERO_BYTE; // R06
			`IDB_POS_VSID:    return `IDB_ZERO_BYTE; // R07
			`IDB_POS_ADDR:    return adr;
			default:          return `IDB_ZERO_BYTE;
		endcase
	endfunction : idb_lookup

	assign look_byte = idb_lookup(dib_index, iface_byte, version_byte, client_address);

	// Registered byte lookup for the transport side.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			dib_byte <= `IDB_ZERO_BYTE;
		else
			dib_byte <= look_byte;
	end

	// Address is latched once from the sampled straps and held until reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			client_address       <= `IDB_ADDR_BASE;
			client_address_valid <= 1'b0;
		end else if (strap.valid && !client_address_valid) begin // R13
			client_address       <= next_client_address; // R08
			client_address_valid <= 1'b1;
		end
	end

	// Streams exactly the requested count of identity bytes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= IDB_IDLE;
			send_idx  <= 4'h0;
			send_len  <= `IDB_SHORT_BYTES;
			dib_valid <= 1'b0;
			dib_last  <= 1'b0;
		end else begin
			case (state)
				IDB_IDLE: begin
					dib_valid <= 1'b0;
					dib_last  <= 1'b0;
					send_idx  <= 4'h0;
					if (dib_req || sw_start) begin
						send_len <= ((dib_req && dib_len16) || (sw_start && sw_len16)) ? `IDB_BLOCK_BYTES
							: `IDB_SHORT_BYTES; // R10
						state    <= IDB_SEND;
					end
				end
				IDB_SEND: begin
					dib_valid <= 1'b1;
					dib_last  <= ({1'b0, send_idx} == send_len - 5'h01); // R10
					if ({1'b0, send_idx} == send_len - 5'h01)
						state <= IDB_DONE;
					else
						send_idx <= send_idx + 4'h1;
				end
				IDB_DONE: begin
					dib_valid <= 1'b0;
					dib_last  <= 1'b0;
					state     <= IDB_IDLE;
				end
				default: state <= IDB_IDLE;
			endcase
		end
	end

	// AXI4-Lite write channel.
	assign awready = !have_aw && !bvalid;
	assign wready  = !have_w && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw    <= 1'b0;
			have_w     <= 1'b0;
			aw_addr    <= 4'h0;
			w_data     <= 32'h0000_0000;
			w_strb     <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= 2'h0;
			prerelease <= 1'b0;
			sw_len16   <= 1'b0;
			sw_index   <= 4'h0;
			sw_start   <= 1'b0;
		end else begin
			sw_start <= 1'b0;
			if (awvalid && awready) begin
				have_aw <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				have_w <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (have_aw && have_w) begin
				have_aw <= 1'b0;
				have_w  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= 2'h0;
				case (aw_addr)
					`IDB_REG_CTRL: if (w_strb[0]) begin
						prerelease <= w_data[`IDB_CTRL_PRERELEASE];
						sw_len16   <= w_data[`IDB_CTRL_LEN16];
						sw_start   <= w_data[`IDB_CTRL_START];
					end
					`IDB_REG_INDEX: if (w_strb[0])
						sw_index <= w_data[3:0];
					`IDB_REG_STATUS, `IDB_REG_DATA: bresp <= 2'h0;
					default: bresp <= 2'h2;
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel.
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= 2'h0;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= 2'h0;
			case (araddr)
				`IDB_REG_CTRL:   rdata <= {30'h0000_0000, sw_len16, prerelease};
				`IDB_REG_STATUS: rdata <= {22'h00_0000, (state != IDB_IDLE), client_address_valid, client_address};
				`IDB_REG_INDEX:  rdata <= {28'h000_0000, sw_index};
				`IDB_REG_DATA:   rdata <= {24'h00_0000, idb_lookup(sw_index, iface_byte, version_byte, client_address)};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= 2'h2;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	property p_iface_value;
		@(posedge aclk) disable iff (!aresetn) (dib_index == `IDB_POS_IFACE) |=> dib_byte == 8'h02;
	endproperty
	a_iface_value: assert property (p_iface_value) else $error("Interface byte wrong."); // R01
	property p_iface_reserved;
		@(posedge aclk) disable iff (!aresetn) (dib_index == `IDB_POS_IFACE) |=> dib_byte[7:6] == 2'h0;
	endproperty
	a_iface_reserved: assert property (p_iface_reserved) else $error("Reserved bits set."); // R02

	property p_zero_fields;
		@(posedge aclk) disable iff (!aresetn)
			(dib_index inside {4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC}) |=> dib_byte == 8'h00;
	endproperty
	a_zero_fields: assert property (p_zero_fields) else $error("Zero field not zero."); // R04
	property p_vid_order;
		@(posedge aclk) disable iff (!aresetn) (dib_index == 4'h2) |=> dib_byte == VENDOR_ID[7:0];
	endproperty
	a_vid_order: assert property (p_vid_order) else $error("Vendor id order wrong."); // R11
	property p_version;
		@(posedge aclk) disable iff (!aresetn) (dib_index == 4'h1) |=> dib_byte[6:0] == 7'h10;
	endproperty
	a_version: assert property (p_version) else $error("Version byte wrong."); // R12

	property p_addr_range;
		@(posedge aclk) disable iff (!aresetn)
			client_address_valid |-> (client_address >= 8'h48 && client_address <= 8'h50);
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("Address out of range."); // R08

	property p_addr_hold;
		@(posedge aclk) disable iff (!aresetn) client_address_valid |=> $stable(client_address);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("Address changed."); // R13
	property p_addr_sampled;
		@(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> ##[1:6] client_address_valid;
	endproperty
	a_addr_sampled: assert property (p_addr_sampled) else $error("Address not sampled."); // R13

	property p_short_len;
		@(posedge aclk) disable iff (!aresetn)
			(state == IDB_IDLE && dib_req && !dib_len16 && !sw_start) |=> ##8 (dib_last && send_idx == 4'h7);
	endproperty
	a_short_len: assert property (p_short_len) else $error("Short block length wrong."); // R10
endmodule : idb_identity_block

// [dv/idb_host_model.sv]
module idb_host_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       go,
	input  wire logic       len16,
	input  wire logic [3:0] idx,
	input  wire logic       dib_valid,
	input  wire logic       dib_last,
	output logic            dib_req,
	output logic            dib_len16,
	output logic [3:0]      dib_index,
	output logic [4:0]      count,
	output logic            done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic vd_q;
	// Issues one identity request of 8 or 16 bytes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dib_req   <= 1'b0;
			dib_len16 <= 1'b0;
		end else begin
			dib_req   <= go;
			dib_len16 <= len16;
		end
	end
	always_ff @(posedge aclk) begin
		dib_index <= idx;
	end
	// Counts the bytes of each stream.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vd_q  <= 1'b0;
			count <= 5'h00;
			done  <= 1'b0;
		end else begin
			vd_q <= dib_valid;
			done <= dib_last;
			if (dib_valid && !vd_q) begin
				count <= 5'h01;
			end else if (dib_valid) begin
				count <= count + 5'h01;
			end
		end
	end
endmodule : idb_host_model

// [dv/idb_identity_block_tb_top.sv]
`include "idb_defs.svh"

module idb_identity_block_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Identity values are arbitrary.
	localparam logic [15:0] VID = 16'h1357;
	localparam logic [15:0] DID = 16'h2468;
	logic aclk, aresetn, s_lh, s_ll, s_hh, s_hl;
	logic [3:0] awaddr, araddr, dib_index, idx;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, go, len16;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, bs, rs;
	logic [7:0] dib_byte, client_address, adr;
	logic dib_req, dib_len16, dib_valid, dib_last, client_address_valid, done;
	logic [4:0] count;
	int err_total, checks_done, l, h, i;
	idb_identity_block #(.VENDOR_ID(VID), .DEVICE_ID(DID), .CAPS(8'h00)) i_idb_identity_block (
		.aclk(aclk), .aresetn(aresetn), .address_strap_low_hi(s_lh), .address_strap_low_lo(s_ll),
		.address_strap_high_hi(s_hh), .address_strap_high_lo(s_hl), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dib_index(dib_index),
		.dib_byte(dib_byte), .dib_req(dib_req), .dib_len16(dib_len16), .dib_valid(dib_valid),
		.dib_last(dib_last), .client_address(client_address), .client_address_valid(client_address_valid));
	idb_host_model i_idb_host_model (
		.aclk(aclk), .aresetn(aresetn), .go(go), .len16(len16), .idx(idx), .dib_valid(dib_valid),
		.dib_last(dib_last), .dib_req(dib_req), .dib_len16(dib_len16), .dib_index(dib_index),
		.count(count), .done(done));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task report_and_stop;
		if (err_total == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task hang;
		err_total++;
		$display("[FAIL] %0t wait timed out", $time);
		report_and_stop();
	endtask : hang
	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				break;
			end
		end
		bs = bresp;
		bready <= 1'b0;
		if (n == 50) begin
			hang();
		end
		@(posedge aclk);
	endtask : axi_wr
	task axi_rd(input logic [3:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				break;
			end
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 50) begin
			hang();
		end
		@(posedge aclk);
	endtask : axi_rd
	task wait_sig(input int which);
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if ((which == 0) ? client_address_valid : done) begin
				break;
			end
		end
		if (n == 60) begin
			hang();
		end
	endtask : wait_sig
	function automatic logic [7:0] exp_byte(input int k, input logic pre);
		case (k)
			1: return {pre, 3'h1, 4'h0};
			2: return VID[7:0];
			3: return VID[15:8];
			4: return DID[7:0];
			5: return DID[15:8];
			6: return 8'h02;
			13: return adr;
			default: return 8'h00;
		endcase
	endfunction : exp_byte
	initial begin
		err_total = 0;
		checks_done = 0;
		{aresetn, s_lh, s_ll, s_hh, s_hl, awvalid, wvalid, bready, arvalid, rready, go, len16} <= 12'h000;
		{awaddr, araddr, idx, wstrb} <= 16'h000F;
		wdata <= 32'h0;
		for (h = 0; h < 3; h++) begin
			for (l = 0; l < 3; l++) begin
				s_lh <= (l != 0);
				s_ll <= (l == 2);
				s_hh <= (h == 2);
				s_hl <= (h != 0);
				aresetn <= 1'b0;
				repeat (3) @(posedge aclk);
				aresetn <= 1'b1;
				adr = 8'h48 + 8'(l) + 8'(3 * h);
				wait_sig(0);
				chk(client_address, adr);
				s_lh <= ~s_lh;
				s_hl <= ~s_hl;
				repeat (8) @(posedge aclk);
				chk(client_address, adr);
			end
		end
		for (i = 0; i < 16; i++) begin
			axi_wr(`IDB_REG_INDEX, i);
			axi_rd(`IDB_REG_DATA);
			chk(rd, exp_byte(i, 1'b0));
			idx <= i[3:0];
			repeat (3) @(posedge aclk);
			chk(dib_byte, exp_byte(i, 1'b0));
		end
		axi_wr(`IDB_REG_CTRL, 32'h1);
		chk(bs, 2'h0);
		axi_wr(`IDB_REG_INDEX, 32'h1);
		axi_rd(`IDB_REG_DATA);
		chk(rd, 32'h90);
		axi_rd(`IDB_REG_STATUS);
		chk(rd, {23'h0, 1'b1, adr});
		axi_rd(4'h2);
		chk(rs, 2'h2);
		axi_wr(4'h2, 32'h0);
		chk(bs, 2'h2);
		for (i = 0; i < 2; i++) begin
			go <= 1'b1;
			len16 <= i[0];
			@(posedge aclk);
			go <= 1'b0;
			wait_sig(1);
			repeat (3) @(posedge aclk);
			chk(count, i ? 5'h10 : 5'h08);
		end
		axi_wr(`IDB_REG_CTRL, 32'h4);
		wait_sig(1);
		repeat (3) @(posedge aclk);
		chk(count, 5'h08);
		axi_wr(`IDB_REG_CTRL, 32'h6);
		wait_sig(1);
		repeat (3) @(posedge aclk);
		chk(count, 5'h10);
		report_and_stop();
	end
endmodule : idb_identity_block_tb_top
